// >>> hdl/wdt_controller.sv
// controller end: wishbone slave for software, apb master toward the watchdog,
// count enable divider and reset pulse generation
// assumes the watchdog end runs on the same clk (edges synchronous, equal rate)
//
// The implementer's own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
module wdt_controller
    import wdt_pkg::*;
#(
    parameter int DIV_W = 16
)
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        wb_cyc,
    input  wire logic        wb_stb,
    input  wire logic        wb_we,
    input  wire logic [7:0]  wb_adr,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack,
    wdt_link_if.host         link
);
    typedef enum logic [1:0] {APB_IDLE, APB_SETUP, APB_ACCESS} apb_state_t;

    typedef struct packed {
        apb_state_t        apb;
        logic              ack;
        logic [31:0]       dat_o;
        logic [ADDR_W-1:0] cmd_addr;
        logic [31:0]       cmd_wdata;
        logic [31:0]       rdata;
        logic              done;
        logic [DIV_W-1:0]  divider;
        logic [DIV_W-1:0]  div_count;
        logic              count_clock_enable;
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0]       pwdata;
        logic              preset_n;
        logic              count_domain_reset_n;
    } host_state_t;

    host_state_t state_reg;
    host_state_t state_next;
    logic        wb_req;
    logic        wb_commit;
    logic [31:0] merged;

    assign wb_req = wb_cyc && wb_stb && !state_reg.ack;
    // writes land at the ack edge, while the master still holds its data
    assign wb_commit = wb_cyc && wb_stb && wb_we && state_reg.ack;

    always_comb begin
        state_next = state_reg;
        merged     = state_reg.cmd_wdata;
        for (int i = 0; i < 4; i++) begin
            if (wb_sel[i]) begin
                merged[8*i +: 8] = wb_dat_i[8*i +: 8];
            end
        end
        // reset pulses last one cycle, which meets the one-period minimum
        state_next.preset_n             = 1'b1;
        state_next.count_domain_reset_n = 1'b1;
        state_next.ack                  = wb_req;
        // count enable: one pulse every divider+1 clocks, never faster than clk
        if (state_reg.div_count >= state_reg.divider) begin
            state_next.div_count          = '0;
            state_next.count_clock_enable = 1'b1;
        end else begin
            state_next.div_count          = state_reg.div_count + 1'b1;
            state_next.count_clock_enable = 1'b0;
        end
        case (state_reg.apb)
            APB_IDLE: begin
                state_next.psel    = 1'b0;
                state_next.penable = 1'b0;
            end
            APB_SETUP: begin
                state_next.penable = 1'b1;
                state_next.apb     = APB_ACCESS;
            end
            APB_ACCESS: begin
                state_next.psel    = 1'b0;
                state_next.penable = 1'b0;
                state_next.rdata   = state_reg.pwrite ? state_reg.rdata : link.prdata;
                state_next.done    = 1'b1;
                state_next.apb     = APB_IDLE;
            end
            default: begin
                state_next.apb = APB_IDLE;
            end
        endcase
        if (wb_commit) begin
            case (wb_adr)
                HOFS_ADDR:    state_next.cmd_addr  = merged[ADDR_W-1:0];
                HOFS_WDATA:   state_next.cmd_wdata = merged;
                HOFS_DIVIDER: state_next.divider   = merged[DIV_W-1:0];
                HOFS_COMMAND: begin
                    // a command while a transfer runs is dropped
                    if (wb_dat_i[CMD_GO_BIT] && state_reg.apb == APB_IDLE) begin
                        state_next.apb     = APB_SETUP;
                        state_next.psel    = 1'b1;
                        state_next.penable = 1'b0;
                        state_next.pwrite  = wb_dat_i[CMD_WRITE_BIT];
                        state_next.paddr   = state_reg.cmd_addr;
                        state_next.pwdata  = state_reg.cmd_wdata;
                        state_next.done    = 1'b0;
                    end
                end
                HOFS_RESETS: begin
                    state_next.preset_n             = !wb_dat_i[RST_BUS_BIT];
                    state_next.count_domain_reset_n = !wb_dat_i[RST_COUNT_BIT];
                end
                default: begin
                end
            endcase
        end
        if (wb_req) begin
            case (wb_adr)
                HOFS_ADDR:    state_next.dat_o = {20'h00000, state_reg.cmd_addr};
                HOFS_WDATA:   state_next.dat_o = state_reg.cmd_wdata;
                HOFS_STATUS:  state_next.dat_o = {28'h0000000, state_reg.done,
                                                  link.system_reset_out,
                                                  link.timeout_irq_out,
                                                  state_reg.apb != APB_IDLE};
                HOFS_RDATA:   state_next.dat_o = state_reg.rdata;
                HOFS_DIVIDER: state_next.dat_o = 32'(state_reg.divider);
                default:      state_next.dat_o = 32'h00000000;
            endcase
        end
        if (rst) begin
            state_next.apb                  = APB_IDLE;
            state_next.ack                  = 1'b0;
            state_next.dat_o                = 32'h00000000;
            state_next.cmd_addr             = '0;
            state_next.cmd_wdata            = 32'h00000000;
            state_next.rdata                = 32'h00000000;
            state_next.done                 = 1'b0;
            state_next.divider              = DIV_W'(DIVIDER_RESET);
            state_next.div_count            = '0;
            state_next.count_clock_enable   = 1'b0;
            state_next.psel                 = 1'b0;
            state_next.penable              = 1'b0;
            state_next.pwrite               = 1'b0;
            state_next.paddr                = '0;
            state_next.pwdata               = 32'h00000000;
            state_next.preset_n             = 1'b0;
            state_next.count_domain_reset_n = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        state_reg <= state_next;
    end

    assign wb_dat_o                  = state_reg.dat_o;
    assign wb_ack                    = state_reg.ack;
    assign link.psel                 = state_reg.psel;
    assign link.penable              = state_reg.penable;
    assign link.pwrite               = state_reg.pwrite;
    assign link.paddr                = state_reg.paddr;
    assign link.pwdata               = state_reg.pwdata;
    assign link.preset_n             = state_reg.preset_n;
    assign link.count_domain_reset_n = state_reg.count_domain_reset_n;
    assign link.count_clock_enable   = state_reg.count_clock_enable;
endmodule : wdt_controller

// >>> hdl/wdt_pkg.sv
// constants shared by both ends of the watchdog link
// assumes one common clock feeds both ends
package wdt_pkg;
    localparam int          ADDR_W          = 12;
    localparam int          DATA_W          = 32;
    // device register offsets
    localparam logic [11:0] OFS_RELOAD      = 12'h000;
    localparam logic [11:0] OFS_VALUE       = 12'h004;
    localparam logic [11:0] OFS_CONTROL     = 12'h008;
    localparam logic [11:0] OFS_IRQ_CLEAR   = 12'h00c;
    localparam logic [11:0] OFS_RAW_STATUS  = 12'h010;
    localparam logic [11:0] OFS_MASK_STATUS = 12'h014;
    localparam logic [11:0] OFS_WRITE_LOCK  = 12'hc00;
    // control field positions
    localparam int          CTRL_IRQ_EN_BIT = 0;
    localparam int          CTRL_RES_EN_BIT = 1;
    // values
    localparam logic [31:0] UNLOCK_KEY      = 32'h1acce551;
    localparam logic [31:0] RELOAD_RESET    = 32'hffffffff;
    localparam logic [31:0] COUNT_RESET     = 32'hffffffff;
    localparam logic [31:0] LOCKED_STATUS   = 32'h00000001;
    localparam logic [31:0] UNLOCKED_STATUS = 32'h00000000;
    // controller register offsets (wishbone byte addresses)
    localparam logic [7:0]  HOFS_ADDR       = 8'h00;
    localparam logic [7:0]  HOFS_WDATA      = 8'h04;
    localparam logic [7:0]  HOFS_COMMAND    = 8'h08;
    localparam logic [7:0]  HOFS_STATUS     = 8'h0c;
    localparam logic [7:0]  HOFS_RDATA      = 8'h10;
    localparam logic [7:0]  HOFS_DIVIDER    = 8'h14;
    localparam logic [7:0]  HOFS_RESETS     = 8'h18;
    // command bits
    localparam int          CMD_GO_BIT      = 0;
    localparam int          CMD_WRITE_BIT   = 1;
    // resets register bits
    localparam int          RST_BUS_BIT     = 0;
    localparam int          RST_COUNT_BIT   = 1;
    // status bits
    localparam int          ST_BUSY_BIT     = 0;
    localparam int          ST_IRQ_BIT      = 1;
    localparam int          ST_SYSRST_BIT   = 2;
    localparam int          ST_DONE_BIT     = 3;
    localparam logic [15:0] DIVIDER_RESET   = 16'h0000;
endpackage : wdt_pkg

// >>> hdl/wdt_link_if.sv
// apb-style link between controller and watchdog, plus count and reset lines
// assumes both ends sit on the same clock
`timescale 1ns/1ps
interface wdt_link_if;
    import wdt_pkg::*;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [DATA_W-1:0] prdata;
    logic              preset_n;
    logic              count_domain_reset_n;
    logic              count_clock_enable;
    logic              system_reset_out;
    logic              timeout_irq_out;

    modport device (
        input  psel, penable, pwrite, paddr, pwdata, preset_n,
               count_domain_reset_n, count_clock_enable,
        output prdata, system_reset_out, timeout_irq_out
    );
    modport host (
        output psel, penable, pwrite, paddr, pwdata, preset_n,
               count_domain_reset_n, count_clock_enable,
        input  prdata, system_reset_out, timeout_irq_out
    );
endinterface : wdt_link_if

// >>> hdl/apb_watchdog_timer.sv
// watchdog end: 32-bit reloading down-counter with irq, reset output and write lock
// assumes the link is driven from logic on the same clk, so no synchronisers
// count_clock is clk gated by count_clock_enable
// both resets come as one-cycle pulses
`timescale 1ns/1ps
module apb_watchdog_timer
    import wdt_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    wdt_link_if.device link
);
    typedef struct packed {
        logic [31:0] reload_value;
        // counter domain
        logic [31:0] count;
        logic        irq_enable;
        logic        reset_out_enable;
        // blocks all but lock writes
        logic        locked;
        logic        raw_irq_status;
        // enable rose: load next
        logic        load_pending;
        // halted after reset out
        logic        stopped;
        logic        system_reset_out;
        // raw and enable, registered
        logic        timeout_irq_out;
        // caught in setup
        logic [31:0] prdata;
    } dev_state_t;

    dev_state_t state_reg;
    dev_state_t state_next;

    logic       bus_write;
    logic       bus_read;
    logic       write_open;
    logic       raw_set_now;
    logic       count_step;

    assign bus_write  = link.psel && link.penable && link.pwrite;

    // read data is caught in the setup phase so it stands through the access phase
    assign bus_read   = link.psel && !link.penable && !link.pwrite;
    assign write_open = !state_reg.locked;

    // moves on enabled edges only
    assign count_step = link.count_clock_enable && state_reg.irq_enable
                        && !state_reg.stopped;

    always_comb begin
        state_next  = state_reg;
        raw_set_now = 1'b0;

        // counting only while enabled and not halted by a reset request
        if (count_step) begin
            if (state_reg.load_pending) begin
                // load before first step
                state_next.count        = state_reg.reload_value;
                state_next.load_pending = 1'b0;
            end else if (state_reg.count == 32'h00000000) begin
                // unserviced: escalate
                if (state_reg.raw_irq_status && state_reg.reset_out_enable) begin
                    state_next.system_reset_out = 1'b1;
                    state_next.stopped          = 1'b1;
                end else begin
                    // zero reached: irq plus reload gives load+1 periods per interval
                    state_next.raw_irq_status = 1'b1;
                    // set survives a clear
                    raw_set_now               = !state_reg.raw_irq_status;
                    state_next.count          = state_reg.reload_value;
                end
            end else begin
                // zero caught above
                state_next.count = state_reg.count - 32'h00000001;
            end
        end

        // writes land at access
        if (bus_write) begin
            case (link.paddr)
                OFS_WRITE_LOCK: begin
                    // always writable
                    state_next.locked = (link.pwdata != UNLOCK_KEY);
                end

                OFS_RELOAD: begin
                    if (write_open) begin
                        state_next.reload_value = link.pwdata;
                        // raw status untouched here on purpose
                        // frozen stays frozen
                        if (state_reg.irq_enable && !state_reg.stopped) begin
                            state_next.count        = link.pwdata;
                            state_next.load_pending = 1'b0;
                        end
                    end
                end

                OFS_CONTROL: begin
                    if (write_open) begin
                        state_next.irq_enable       = link.pwdata[CTRL_IRQ_EN_BIT];
                        state_next.reset_out_enable = link.pwdata[CTRL_RES_EN_BIT];
                        // only 0 to 1 reloads
                        if (link.pwdata[CTRL_IRQ_EN_BIT] && !state_reg.irq_enable) begin
                            state_next.load_pending = 1'b1;
                        end
                    end
                end

                OFS_IRQ_CLEAR: begin
                    if (write_open) begin
                        // an irq raised in this very cycle survives the clear
                        state_next.raw_irq_status = raw_set_now;
                        // halted until count reset
                        if (!state_reg.stopped) begin
                            state_next.count        = state_next.reload_value;
                            state_next.load_pending = 1'b0;
                        end
                    end
                end

                default: begin
                end
            endcase
        end

        // reads ignore the lock
        if (bus_read) begin
            case (link.paddr)
                OFS_RELOAD:      state_next.prdata = state_reg.reload_value;
                OFS_VALUE:       state_next.prdata = state_reg.count;
                OFS_CONTROL:     state_next.prdata = {30'h00000000,
                                                      state_reg.reset_out_enable,
                                                      state_reg.irq_enable};
                OFS_RAW_STATUS:  state_next.prdata = {31'h00000000, state_reg.raw_irq_status};
                OFS_MASK_STATUS: state_next.prdata = {31'h00000000, state_reg.timeout_irq_out};
                // status, not the key
                OFS_WRITE_LOCK:  state_next.prdata = state_reg.locked ? LOCKED_STATUS
                                                                      : UNLOCKED_STATUS;
                default:         state_next.prdata = 32'h00000000;
            endcase
        end

        // resets override writes
        if (rst || !link.preset_n) begin
            // longest timeout
            state_next.reload_value     = RELOAD_RESET;
            state_next.irq_enable       = 1'b0;
            state_next.reset_out_enable = 1'b0;
            state_next.locked           = 1'b0;
            state_next.load_pending     = 1'b0;
            state_next.prdata           = 32'h00000000;
        end

        // count domain only
        if (rst || !link.count_domain_reset_n) begin
            // idle at all ones
            state_next.count            = COUNT_RESET;
            state_next.raw_irq_status   = 1'b0;
            state_next.load_pending     = 1'b0;
            state_next.stopped          = 1'b0;
            // only way out of reset out
            state_next.system_reset_out = 1'b0;
        end

        // masked status is registered from the next state so the pin drops one cycle after the clearing write
        state_next.timeout_irq_out = state_next.raw_irq_status
                                     && state_next.irq_enable;
    end

    // one register stage
    always_ff @(posedge clk) begin
        state_reg <= state_next;
    end

    // outputs straight from flops
    assign link.prdata           = state_reg.prdata;
    assign link.system_reset_out = state_reg.system_reset_out;
    assign link.timeout_irq_out  = state_reg.timeout_irq_out;
endmodule : apb_watchdog_timer

// >>> test/wdt_link_sva.sv
// checker for the watchdog link: apb phases, lock status, irq and reset outputs
// assumes both ends share clk and rst; it sees the interface signals only
`timescale 1ns/1ps
module wdt_link_sva
    import wdt_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic              preset_n,
    input wire logic              count_domain_reset_n,
    input wire logic              count_clock_enable,
    input wire logic              system_reset_out,
    input wire logic              timeout_irq_out
);
    logic locked_reg;
    logic irq_en_reg;
    logic res_en_reg;
    logic apb_wr;
    // shadow of lock and control, rebuilt from completed apb writes
    assign apb_wr = psel && penable && pwrite;
    always_ff @(posedge clk) begin
        if (rst || !preset_n) begin
            locked_reg <= 1'b0;
            irq_en_reg <= 1'b0;
            res_en_reg <= 1'b0;
        end else if (apb_wr && paddr == OFS_WRITE_LOCK) begin
            locked_reg <= (pwdata != UNLOCK_KEY);
        end else if (apb_wr && paddr == OFS_CONTROL && !locked_reg) begin
            irq_en_reg <= pwdata[CTRL_IRQ_EN_BIT];
            res_en_reg <= pwdata[CTRL_RES_EN_BIT];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    apb_phase_a: assert property ($rose(psel) |=> psel && penable ##1 !psel && !penable)
        else $error("apb setup and access phases out of order");
    lock_read_a: assert property (psel && penable && !pwrite && paddr == OFS_WRITE_LOCK
        |-> prdata == (locked_reg ? LOCKED_STATUS : UNLOCKED_STATUS))
        else $error("lock register read returned wrong status");
    irq_clear_fast_a: assert property (apb_wr && paddr == OFS_IRQ_CLEAR && !locked_reg
        |=> !timeout_irq_out)
        else $error("irq still high after unlocked clear");
    irq_masked_a: assert property (timeout_irq_out |-> irq_en_reg)
        else $error("irq high while irq enable is clear");
    irq_cause_a: assert property ($rose(timeout_irq_out)
        |-> $past(count_clock_enable) || $past(apb_wr))
        else $error("irq rose without count edge or bus write");
    irq_hold_a: assert property (timeout_irq_out && !apb_wr && preset_n
        && count_domain_reset_n |=> timeout_irq_out)
        else $error("pending irq dropped without a write");
    sysrst_cause_a: assert property ($rose(system_reset_out)
        |-> $past(count_clock_enable) && $past(timeout_irq_out) && $past(res_en_reg))
        else $error("reset out rose without pending irq and enable");
    sysrst_hold_a: assert property (system_reset_out && preset_n && count_domain_reset_n
        |=> system_reset_out)
        else $error("reset out dropped without a reset");
    reset_quiet_a: assert property (!preset_n && !count_domain_reset_n
        |=> !timeout_irq_out && !system_reset_out)
        else $error("outputs not cleared by reset pulses");
endmodule : wdt_link_sva

// >>> test/apb_watchdog_timer_tb_top.sv
// testbench: controller and watchdog joined by the link, driven over wishbone
// assumes one 20 MHz clock and a synchronous active-high reset for both ends
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("mismatch at %0t got %h expected %h", $time, (got), (exp)); end end
module apb_watchdog_timer_tb_top
    import wdt_pkg::*;
;
    logic        clk      = 1'b0;
    logic        rst      = 1'b1;
    logic        wb_cyc   = 1'b0;
    logic        wb_stb   = 1'b0;
    logic        wb_we    = 1'b0;
    logic [7:0]  wb_adr   = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0]  wb_sel   = 4'hf;
    logic [31:0] wb_dat_o;
    logic        wb_ack;
    int          n_mismatch = 0;
    int          n_compared = 0;
    wdt_link_if link ();
    apb_watchdog_timer i_apb_watchdog_timer (.clk(clk), .rst(rst), .link(link.device));
    wdt_controller #(.DIV_W(16)) i_wdt_controller (.clk(clk), .rst(rst), .wb_cyc(wb_cyc),
        .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_dat_i(wb_dat_i),
        .wb_sel(wb_sel), .wb_dat_o(wb_dat_o), .wb_ack(wb_ack), .link(link.host));
    wdt_link_sva i_wdt_link_sva (.clk(clk), .rst(rst), .psel(link.psel),
        .penable(link.penable), .pwrite(link.pwrite), .paddr(link.paddr),
        .pwdata(link.pwdata), .prdata(link.prdata), .preset_n(link.preset_n),
        .count_domain_reset_n(link.count_domain_reset_n),
        .count_clock_enable(link.count_clock_enable),
        .system_reset_out(link.system_reset_out), .timeout_irq_out(link.timeout_irq_out));
    always #25 clk = ~clk;

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test

    // one classic wishbone cycle; the request stands until ack is sampled
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                      output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc   <= 1'b1;
        wb_stb   <= 1'b1;
        wb_we    <= we;
        wb_adr   <= adr;
        wb_dat_i <= dat;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 64);
        q = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        if (wb_ack !== 1'b1) begin
            n_mismatch++;
            end_of_test();
        end
    endtask : wb

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] q;
        wb(1'b1, adr, dat, q);
    endtask : wr

    // one device access through the controller: address, data, go, poll busy
    task automatic dev(input logic we, input logic [11:0] ofs, input logic [31:0] dat,
                       output logic [31:0] q);
        logic [31:0] st;
        int          n;
        n = 0;
        wr(HOFS_ADDR, {20'h00000, ofs});
        wr(HOFS_WDATA, dat);
        wr(HOFS_COMMAND, {30'h0, we, 1'b1});
        do begin
            wb(1'b0, HOFS_STATUS, 32'h0, st);
            n++;
        end while (st[ST_BUSY_BIT] !== 1'b0 && n < 16);
        if (st[ST_BUSY_BIT] !== 1'b0) begin
            n_mismatch++;
            end_of_test();
        end
        wb(1'b0, HOFS_RDATA, 32'h0, q);
    endtask : dev

    task automatic dwr(input logic [11:0] ofs, input logic [31:0] dat);
        logic [31:0] q;
        dev(1'b1, ofs, dat, q);
    endtask : dwr

    task automatic drd(input logic [11:0] ofs, output logic [31:0] q);
        dev(1'b0, ofs, 32'h0, q);
    endtask : drd

    task automatic exp_rd(input logic [11:0] ofs, input logic [31:0] exp);
        logic [31:0] q;
        drd(ofs, q);
        `CHK(q, exp)
    endtask : exp_rd

    // bounded wait for irq (which=0) or reset out (which=1); returns cycles waited
    task automatic wait_out(input bit which, output int n);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while ((which ? link.system_reset_out : link.timeout_irq_out) !== 1'b1
                   && n < 4000);
        if (n >= 4000) begin
            n_mismatch++;
            end_of_test();
        end
    endtask : wait_out

    // pulses both resets, then checks the documented reset state
    task automatic fresh(input logic [15:0] div);
        wr(HOFS_RESETS, 32'h3);
        wr(HOFS_DIVIDER, {16'h0, div});
        exp_rd(OFS_WRITE_LOCK, UNLOCKED_STATUS);
        exp_rd(OFS_RELOAD, RELOAD_RESET);
        exp_rd(OFS_CONTROL, 32'h0);
        exp_rd(OFS_VALUE, COUNT_RESET);
    endtask : fresh

    task automatic test_timeout(input logic [31:0] load, input logic [15:0] div);
        int          n;
        logic [31:0] v1;
        logic [31:0] v2;
        logic [31:0] st;
        fresh(div);
        dwr(OFS_RELOAD, load);
        dwr(OFS_CONTROL, 32'h3);
        wait_out(1'b0, n);
        wait_out(1'b1, n);
        wb(1'b0, HOFS_STATUS, 32'h0, st);
        `CHK(st[ST_SYSRST_BIT], 1'b1)
        `CHK(st[ST_IRQ_BIT], 1'b1)
        `CHK(32'(n), 32'((load + 1) * (div + 1)))
        drd(OFS_VALUE, v1);
        drd(OFS_VALUE, v2);
        `CHK(v2, v1)
        exp_rd(OFS_RAW_STATUS, 32'h1);
        $display("timeout test done load %h divider %h", load, div);
    endtask : test_timeout

    task automatic test_lock();
        fresh(16'h0000);
        dwr(OFS_WRITE_LOCK, 32'h0);
        exp_rd(OFS_WRITE_LOCK, LOCKED_STATUS);
        dwr(OFS_RELOAD, 32'h10);
        dwr(OFS_CONTROL, 32'h1);
        exp_rd(OFS_RELOAD, RELOAD_RESET);
        exp_rd(OFS_CONTROL, 32'h0);
        dwr(OFS_WRITE_LOCK, UNLOCK_KEY);
        exp_rd(OFS_WRITE_LOCK, UNLOCKED_STATUS);
        dwr(OFS_RELOAD, 32'h10);
        exp_rd(OFS_RELOAD, 32'h10);
        dwr(OFS_WRITE_LOCK, 32'h1);
        $display("lock test done");
    endtask : test_lock

    task automatic test_freeze();
        int          n;
        logic [31:0] v1;
        logic [31:0] v2;
        fresh(16'h0001);
        dwr(OFS_RELOAD, 32'h200);
        dwr(OFS_CONTROL, 32'h1);
        drd(OFS_VALUE, v1);
        drd(OFS_VALUE, v2);
        `CHK(v2 < v1, 1'b1)
        dwr(OFS_CONTROL, 32'h0);
        drd(OFS_VALUE, v1);
        dwr(OFS_RELOAD, 32'h4000);
        drd(OFS_VALUE, v2);
        `CHK(v2, v1)
        dwr(OFS_CONTROL, 32'h1);
        drd(OFS_VALUE, v1);
        `CHK(v1 > 32'h3f00 && v1 <= 32'h4000, 1'b1)
        dwr(OFS_RELOAD, 32'h20);
        wait_out(1'b0, n);
        exp_rd(OFS_MASK_STATUS, 32'h1);
        dwr(OFS_RELOAD, 32'h4000);
        `CHK(link.timeout_irq_out, 1'b1)
        drd(OFS_VALUE, v1);
        `CHK(v1 > 32'h3f00, 1'b1)
        dwr(OFS_IRQ_CLEAR, 32'h0);
        `CHK(link.timeout_irq_out, 1'b0)
        exp_rd(OFS_RAW_STATUS, 32'h0);
        dwr(OFS_RELOAD, 32'h20);
        wait_out(1'b0, n);
        // three full intervals with reset out disabled: irq stays, no reset
        repeat (3 * 33 * 2) @(posedge clk);
        `CHK(link.system_reset_out, 1'b0)
        `CHK(link.timeout_irq_out, 1'b1)
        dwr(OFS_CONTROL, 32'h0);
        `CHK(link.timeout_irq_out, 1'b0)
        exp_rd(OFS_RAW_STATUS, 32'h1);
        exp_rd(OFS_MASK_STATUS, 32'h0);
        $display("freeze and reload test done");
    endtask : test_freeze

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        test_lock();
        test_timeout(32'h5, 16'h2);
        test_timeout(32'h0, 16'h20);
        test_timeout(32'h20, 16'h0);
        test_freeze();
        end_of_test();
    end
endmodule : apb_watchdog_timer_tb_top
